// ---- src/ssio_pkg.sv ----
package ssio_pkg;
  // Clock and time base
  localparam int CLK_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * US_CYC;
  localparam int NIN = 8;
  // Register byte offsets
  localparam logic [7:0] A_IN_SEL = 8'h00;
  localparam logic [7:0] A_OUT_SEL = 8'h04;
  localparam logic [7:0] A_FDLY = 8'h08;
  localparam logic [7:0] A_SCAN = 8'h0c;
  localparam logic [7:0] A_ACT = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_SV1 = 8'h18;
  localparam logic [7:0] A_SV2 = 8'h1c;
  localparam logic [7:0] A_CNT1 = 8'h20;
  localparam logic [7:0] A_CNT2 = 8'h24;
  localparam logic [7:0] A_ADJ0 = 8'h28;
  localparam logic [7:0] A_ADJ1 = 8'h2c;
  localparam logic [7:0] A_PLS = 8'h30;
  localparam logic [7:0] A_PWM = 8'h34;
  localparam logic [7:0] A_IST = 8'h38;
  localparam logic [7:0] A_IMSK = 8'h3c;
  localparam logic [7:0] A_DIN = 8'h40;
  // Reset values and limits
  localparam logic [3:0] FDLY_RST = 4'ha;
  localparam logic [9:0] ADJ_MAX = 10'h3e8;
  localparam logic [15:0] PLS_FMIN = 16'h0032;
  localparam logic [15:0] PLS_FMAX = 16'h1388;
  localparam logic [19:0] PLS_HALF_US = 20'h7a120;
  localparam logic [6:0] PWM_MAX = 7'h64;
  localparam logic [6:0] SPD_NMAX = 7'h64;
  localparam logic [9:0] SPD_STEP_MS = 10'h00a;
  // Mode codes of the select registers
  localparam logic [14:0] IN_CH_MASK = 15'h3000;
  localparam logic [14:0] IN_INT_MASK = 15'h30cc;
  localparam logic [14:0] IN_UP = 15'h0003;
  localparam logic [14:0] IN_SPD = 15'h0403;
  localparam logic [14:0] IN_QUAD = 15'h0803;
  localparam logic [14:0] IN_INT = 15'h0001;
  localparam logic [12:0] OUT_CWCCW = 13'h0003;
  localparam logic [12:0] OUT_PLSDIR = 13'h0007;
  localparam logic [12:0] OUT_PWM = 13'h0001;
  // Field positions
  localparam int B_FON = 15;
  localparam int B_FOFF = 14;
  localparam int B_EN1 = 12;
  localparam int B_EN2 = 13;
  localparam int B_R1 = 2;
  localparam int B_F1 = 3;
  localparam int B_R2 = 6;
  localparam int B_F2 = 7;
  localparam int B_DIR = 16;
  localparam int B_RUN = 17;
endpackage : ssio_pkg

// ---- src/ssio_filt_if.sv ----
`timescale 1ns/1ps
interface ssio_filt_if;
  logic tick;
  logic [3:0] dly;
  logic [ssio_pkg::NIN-1:0] raw;
  logic [ssio_pkg::NIN-1:0] filt;
  modport ctl (output tick, output dly, output raw, input filt);
  modport filt_side (input tick, input dly, input raw, output filt);
endinterface : ssio_filt_if

// ---- src/ssio_filter.sv ----
`timescale 1ns/1ps
module ssio_filter (
  input wire logic mclk,
  input wire logic nrst,
  ssio_filt_if.filt_side fp
);
  for (genvar i = 0; i < ssio_pkg::NIN; i++) begin : g_bit
    logic [4:0] c_reg;
    logic [4:0] c_next;
    logic f_reg;
    logic f_next;
    // On and off delay: the ms tick runs free, so one extra tick is counted
    // to keep any pulse shorter than dly ms out; a change passes after dly to dly+1 ms
    always_comb begin
      c_next = c_reg;
      f_next = f_reg;
      if (fp.raw[i] == f_reg) begin
        c_next = 5'h00;
      end else if (fp.dly == 4'h0 || c_reg > {1'b0, fp.dly}) begin
        f_next = fp.raw[i];
        c_next = 5'h00;
      end else if (fp.tick) begin
        c_next = c_reg + 5'h01;
      end
    end
    // State registers
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        c_reg <= 5'h00;
        f_reg <= 1'b0;
      end else begin
        c_reg <= c_next;
        f_reg <= f_next;
      end
    end
    assign fp.filt[i] = f_reg;
  end
endmodule : ssio_filter

// ---- src/ssio_top.sv ----
`timescale 1ns/1ps
module ssio_top #(
  parameter int MS_CYC = ssio_pkg::MS_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] din,
  input wire logic [9:0] adj0_raw,
  input wire logic [9:0] adj1_raw,
  output logic [7:0] din_filt,
  output logic out_20,
  output logic out_21,
  output logic irq
);
  localparam int MSW = $clog2(MS_CYC);
  ssio_filt_if fif ();
  ssio_filter u_filt (.mclk(mclk), .nrst(nrst), .fp(fif.filt_side));

  // Pin synchroniser; only the second stage feeds logic
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
    end
  end

  // Microsecond and millisecond ticks
  logic [7:0] us_reg;
  logic [7:0] us_next;
  logic [MSW-1:0] ms_reg;
  logic [MSW-1:0] ms_next;
  logic us_tick;
  logic ms_tick;
  always_comb begin
    us_tick = us_reg == 8'(ssio_pkg::US_CYC - 1);
    ms_tick = ms_reg == MSW'(MS_CYC - 1);
    us_next = us_tick ? 8'h00 : us_reg + 8'h01;
    ms_next = ms_tick ? '0 : ms_reg + 1'b1;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      us_reg <= 8'h00;
      ms_reg <= '0;
    end else begin
      us_reg <= us_next;
      ms_reg <= ms_next;
    end
  end

  // AHB-Lite address phase capture; zero wait states, always OKAY
  logic aw_reg;
  logic ar_reg;
  logic [7:0] a_reg;
  logic acc;
  always_comb begin
    acc = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[31:8] == 24'h000000;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_reg <= 1'b0;
      ar_reg <= 1'b0;
      a_reg <= 8'h00;
    end else begin
      aw_reg <= acc && hwrite;
      ar_reg <= acc && !hwrite;
      a_reg <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Software registers and the configuration frozen at the first scan
  logic [15:0] in_sel_reg, in_sel_next, out_sel_reg, out_sel_next;
  logic [15:0] in_act_reg, in_act_next, out_act_reg, out_act_next;
  logic [3:0] fdly_reg, fdly_next, fdly_act_reg, fdly_act_next;
  logic scan_reg, scan_next;
  logic [5:0] ctrl_reg, ctrl_next;
  logic [31:0] sv_reg [2];
  logic [31:0] sv_next [2];
  logic [17:0] pls_reg, pls_next;
  logic [6:0] pwm_reg, pwm_next;
  logic [3:0] st_reg, st_next, msk_reg, msk_next;
  logic [3:0] ev;
  function automatic logic wr(input logic [7:0] a);
    wr = aw_reg && a_reg == a;
  endfunction : wr
  always_comb begin
    in_sel_next = wr(ssio_pkg::A_IN_SEL) ? hwdata[15:0] : in_sel_reg;
    out_sel_next = wr(ssio_pkg::A_OUT_SEL) ? hwdata[15:0] : out_sel_reg;
    fdly_next = wr(ssio_pkg::A_FDLY) ? hwdata[3:0] : fdly_reg;
    ctrl_next = wr(ssio_pkg::A_CTRL) ? hwdata[5:0] : ctrl_reg;
    sv_next[0] = wr(ssio_pkg::A_SV1) ? hwdata : sv_reg[0];
    sv_next[1] = wr(ssio_pkg::A_SV2) ? hwdata : sv_reg[1];
    pls_next = wr(ssio_pkg::A_PLS) ? hwdata[17:0] : pls_reg;
    pwm_next = wr(ssio_pkg::A_PWM) ? hwdata[6:0] : pwm_reg;
    msk_next = wr(ssio_pkg::A_IMSK) ? hwdata[3:0] : msk_reg;
    // A new event wins over a write-one-to-clear in the same cycle
    st_next = (st_reg & ~(wr(ssio_pkg::A_IST) ? hwdata[3:0] : 4'h0)) | ev;
    scan_next = scan_reg;
    in_act_next = in_act_reg;
    out_act_next = out_act_reg;
    fdly_act_next = fdly_act_reg;
    // Only the first scan start copies the setup; later writes stay shadowed
    if (wr(ssio_pkg::A_SCAN) && hwdata[0] && !scan_reg) begin
      scan_next = 1'b1;
      in_act_next = in_sel_reg;
      out_act_next = out_sel_reg;
      fdly_act_next = fdly_reg;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_sel_reg <= 16'h0000;
      out_sel_reg <= 16'h0000;
      fdly_reg <= ssio_pkg::FDLY_RST;
      ctrl_reg <= 6'h00;
      sv_reg[0] <= 32'h00000000;
      sv_reg[1] <= 32'h00000000;
      pls_reg <= 18'h00000;
      pwm_reg <= 7'h00;
      msk_reg <= 4'h0;
      st_reg <= 4'h0;
      scan_reg <= 1'b0;
      in_act_reg <= 16'h0000;
      out_act_reg <= 16'h0000;
      fdly_act_reg <= ssio_pkg::FDLY_RST;
    end else begin
      in_sel_reg <= in_sel_next;
      out_sel_reg <= out_sel_next;
      fdly_reg <= fdly_next;
      ctrl_reg <= ctrl_next;
      sv_reg[0] <= sv_next[0];
      sv_reg[1] <= sv_next[1];
      pls_reg <= pls_next;
      pwm_reg <= pwm_next;
      msk_reg <= msk_next;
      st_reg <= st_next;
      scan_reg <= scan_next;
      in_act_reg <= in_act_next;
      out_act_reg <= out_act_next;
      fdly_act_reg <= fdly_act_next;
    end
  end
  assign irq = |(st_reg & msk_reg);

  // Mode decode of the frozen configuration; exact codes make modes exclusive
  logic mode_up, mode_spd, mode_quad, mode_int, filt_en, mode_cw, mode_pd, mode_pwm;
  logic [1:0] ch_en;
  always_comb begin
    ch_en = in_act_reg[ssio_pkg::B_EN2:ssio_pkg::B_EN1];
    mode_up = (in_act_reg[14:0] & ~ssio_pkg::IN_CH_MASK) == ssio_pkg::IN_UP && ch_en != 2'b00;
    mode_spd = (in_act_reg[14:0] & ~ssio_pkg::IN_CH_MASK) == ssio_pkg::IN_SPD && ch_en != 2'b00;
    mode_quad = in_act_reg[14:0] == ssio_pkg::IN_QUAD;
    mode_int = (in_act_reg[14:0] & ~ssio_pkg::IN_INT_MASK) == ssio_pkg::IN_INT && ch_en != 2'b00;
    filt_en = in_act_reg[ssio_pkg::B_FON] && !in_act_reg[ssio_pkg::B_FOFF]
      && in_act_reg[9:8] == 2'b00 && in_act_reg[5:4] == 2'b00;
    mode_cw = out_act_reg[12:0] == ssio_pkg::OUT_CWCCW;
    mode_pd = out_act_reg[12:0] == ssio_pkg::OUT_PLSDIR;
    mode_pwm = out_act_reg[12:0] == ssio_pkg::OUT_PWM;
  end

  // Filter hookup; without the filter mode the default delay holds
  logic [7:0] fin;
  assign fif.tick = ms_tick;
  assign fif.dly = filt_en ? fdly_act_reg : ssio_pkg::FDLY_RST;
  assign fif.raw = s2_reg;
  assign fin = fif.filt;
  assign din_filt = fin;

  // Edge history of filtered inputs and soft-gates
  logic [7:0] fin_d_reg;
  logic [1:0] gate_d_reg;
  logic [7:0] rise, fall;
  logic [1:0] gate;
  logic qstep, qup;
  always_comb begin
    rise = fin & ~fin_d_reg;
    fall = ~fin & fin_d_reg;
    gate = ctrl_reg[1:0];
    qstep = (fin[0] ^ fin_d_reg[0]) ^ (fin[1] ^ fin_d_reg[1]);
    qup = fin[0] ^ fin_d_reg[1];
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fin_d_reg <= 8'h00;
      gate_d_reg <= 2'b00;
    end else begin
      fin_d_reg <= fin;
      gate_d_reg <= gate;
    end
  end

  // Counter channels; channel 0 also carries the 32-bit quadrature count
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [31:0] cnt_reg, cnt_next;
    logic [15:0] acc_reg, acc_next;
    logic [9:0] tms_reg, tms_next, per;
    logic [6:0] n;
    logic hit;
    always_comb begin
      n = sv_reg[i][6:0] == 7'h00 ? 7'h01 : (sv_reg[i][6:0] > ssio_pkg::SPD_NMAX ? ssio_pkg::SPD_NMAX : sv_reg[i][6:0]);
      per = 10'(n * ssio_pkg::SPD_STEP_MS);
      cnt_next = cnt_reg;
      acc_next = acc_reg;
      tms_next = tms_reg;
      hit = 1'b0;
      if (mode_quad && i == 0) begin
        if (!gate[0]) begin
          if (gate_d_reg[0]) cnt_next = 32'h00000000;
          else if (ctrl_reg[2]) cnt_next = sv_reg[0];
          else if (ctrl_reg[3]) cnt_next = sv_reg[1];
        end else if (fin[2]) begin
          cnt_next = 32'h00000000;
        end else if (qstep) begin
          cnt_next = qup ? cnt_reg + 32'h00000001 : cnt_reg - 32'h00000001;
        end
      end else if (mode_up && ch_en[i]) begin
        if (!gate[i]) begin
          if (gate_d_reg[i]) cnt_next = 32'h00000000;
          else if (ctrl_reg[2+i]) cnt_next = {16'h0000, sv_reg[i][15:0]};
        end else if (fin[2+i]) begin
          cnt_next = 32'h00000000;
        end else if (rise[i]) begin
          // Ring counter: reaching the set value wraps to zero and flags it
          if (cnt_reg[15:0] + 16'h0001 == sv_reg[i][15:0]) begin
            cnt_next = 32'h00000000;
            hit = 1'b1;
          end else begin
            cnt_next = {16'h0000, cnt_reg[15:0] + 16'h0001};
          end
        end
      end else if (mode_spd && ch_en[i]) begin
        if (!gate[i]) begin
          cnt_next = 32'h00000000;
          acc_next = 16'h0000;
          tms_next = 10'h000;
        end else begin
          acc_next = acc_reg + {15'h0000, rise[i]};
          if (ms_tick) begin
            if (tms_reg + 10'h001 >= per) begin
              cnt_next = {16'h0000, acc_next};
              acc_next = 16'h0000;
              tms_next = 10'h000;
            end else begin
              tms_next = tms_reg + 10'h001;
            end
          end
        end
      end
    end
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        cnt_reg <= 32'h00000000;
        acc_reg <= 16'h0000;
        tms_reg <= 10'h000;
      end else begin
        cnt_reg <= cnt_next;
        acc_reg <= acc_next;
        tms_reg <= tms_next;
      end
    end
  end

  // Events: counter hits and compares need their enable; edges raise routines 3 and 4
  logic [1:0] qhit;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      qhit[k] = mode_quad && g_ch[0].cnt_next != g_ch[0].cnt_reg && g_ch[0].cnt_next == sv_reg[k];
    end
    ev[0] = ctrl_reg[4] && (g_ch[0].hit || qhit[0]);
    ev[1] = ctrl_reg[5] && (g_ch[1].hit || qhit[1]);
    ev[2] = mode_int && in_act_reg[ssio_pkg::B_EN1] && ((in_act_reg[ssio_pkg::B_R1] && rise[2])
      || (in_act_reg[ssio_pkg::B_F1] && fall[2]));
    ev[3] = mode_int && in_act_reg[ssio_pkg::B_EN2] && ((in_act_reg[ssio_pkg::B_R2] && rise[3])
      || (in_act_reg[ssio_pkg::B_F2] && fall[3]));
  end

  // Analog readout clamped to full scale; converter shares this clock
  logic [9:0] adj_reg [2];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      adj_reg[0] <= 10'h000;
      adj_reg[1] <= 10'h000;
    end else begin
      adj_reg[0] <= adj0_raw > ssio_pkg::ADJ_MAX ? ssio_pkg::ADJ_MAX : adj0_raw;
      adj_reg[1] <= adj1_raw > ssio_pkg::ADJ_MAX ? ssio_pkg::ADJ_MAX : adj1_raw;
    end
  end

  // Pulse and PWM generators; a 1 us accumulator keeps every 1 Hz step exact
  logic [19:0] pacc_reg, pacc_next, psum;
  logic ptog_reg, ptog_next;
  logic [6:0] pwc_reg, pwc_next, duty;
  logic [15:0] freq;
  logic o20_next, o21_next, run, dir;
  always_comb begin
    run = pls_reg[ssio_pkg::B_RUN];
    dir = pls_reg[ssio_pkg::B_DIR];
    freq = pls_reg[15:0] < ssio_pkg::PLS_FMIN ? ssio_pkg::PLS_FMIN
      : (pls_reg[15:0] > ssio_pkg::PLS_FMAX ? ssio_pkg::PLS_FMAX : pls_reg[15:0]);
    duty = pwm_reg > ssio_pkg::PWM_MAX ? ssio_pkg::PWM_MAX : pwm_reg;
    psum = pacc_reg + {4'h0, freq};
    pacc_next = pacc_reg;
    ptog_next = ptog_reg;
    if (!run || !(mode_cw || mode_pd)) begin
      pacc_next = 20'h00000;
      ptog_next = 1'b0;
    end else if (us_tick) begin
      if (psum >= ssio_pkg::PLS_HALF_US) begin
        pacc_next = psum - ssio_pkg::PLS_HALF_US;
        ptog_next = !ptog_reg;
      end else begin
        pacc_next = psum;
      end
    end
    pwc_next = us_tick ? (pwc_reg == ssio_pkg::PWM_MAX - 7'h01 ? 7'h00 : pwc_reg + 7'h01) : pwc_reg;
    o20_next = mode_pwm ? pwc_reg < duty : (mode_pd ? ptog_reg : (mode_cw && ptog_reg && !dir));
    o21_next = mode_pd ? (run && dir) : (mode_cw && ptog_reg && dir);
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pacc_reg <= 20'h00000;
      ptog_reg <= 1'b0;
      pwc_reg <= 7'h00;
      out_20 <= 1'b0;
      out_21 <= 1'b0;
    end else begin
      pacc_reg <= pacc_next;
      ptog_reg <= ptog_next;
      pwc_reg <= pwc_next;
      out_20 <= o20_next;
      out_21 <= o21_next;
    end
  end

  // Read data is registered in the address phase; unmapped offsets read zero, reads with haddr[31:8] nonzero leave hrdata unchanged
  logic [31:0] rd;
  always_comb begin
    unique case (haddr[7:0])
      ssio_pkg::A_IN_SEL: rd = {16'h0000, in_sel_reg};
      ssio_pkg::A_OUT_SEL: rd = {16'h0000, out_sel_reg};
      ssio_pkg::A_FDLY: rd = {28'h0000000, fdly_reg};
      ssio_pkg::A_SCAN: rd = {31'h00000000, scan_reg};
      ssio_pkg::A_ACT: rd = {out_act_reg, in_act_reg};
      ssio_pkg::A_CTRL: rd = {26'h0000000, ctrl_reg};
      ssio_pkg::A_SV1: rd = sv_reg[0];
      ssio_pkg::A_SV2: rd = sv_reg[1];
      ssio_pkg::A_CNT1: rd = g_ch[0].cnt_reg;
      ssio_pkg::A_CNT2: rd = g_ch[1].cnt_reg;
      ssio_pkg::A_ADJ0: rd = {22'h000000, adj_reg[0]};
      ssio_pkg::A_ADJ1: rd = {22'h000000, adj_reg[1]};
      ssio_pkg::A_PLS: rd = {14'h0000, pls_reg};
      ssio_pkg::A_PWM: rd = {25'h0000000, pwm_reg};
      ssio_pkg::A_IST: rd = {28'h0000000, st_reg};
      ssio_pkg::A_IMSK: rd = {28'h0000000, msk_reg};
      ssio_pkg::A_DIN: rd = {24'h000000, fin};
      default: rd = 32'h00000000;
    endcase
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) hrdata <= 32'h00000000;
    else if (acc && !hwrite) hrdata <= rd;
  end

  // Checks
  property p_frozen;
    @(posedge mclk) disable iff (!nrst) $past(scan_reg) |-> $stable(in_act_reg) && $stable(out_act_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("active setup changed after first scan");
  property p_fdly;
    @(posedge mclk) disable iff (!nrst) !filt_en |-> fif.dly == ssio_pkg::FDLY_RST;
  endproperty
  a_fdly: assert property (p_fdly) else $error("filter delay not default");
  property p_up_rst;
    @(posedge mclk) disable iff (!nrst) mode_up && ch_en[0] && gate[0] && fin[2] |=> g_ch[0].cnt_reg == 32'h0;
  endproperty
  a_up_rst: assert property (p_up_rst) else $error("up-counter reset ignored");
  property p_spd_off;
    @(posedge mclk) disable iff (!nrst) mode_spd && ch_en[0] && !gate[0] |=> g_ch[0].cnt_reg == 32'h0;
  endproperty
  a_spd_off: assert property (p_spd_off) else $error("speed hold not cleared");
  property p_quad_dir;
    @(posedge mclk) disable iff (!nrst) mode_quad && gate[0] && !fin[2] && qstep
      |=> g_ch[0].cnt_reg == $past(g_ch[0].cnt_reg) + ($past(qup) ? 32'h1 : 32'hffffffff);
  endproperty
  a_quad_dir: assert property (p_quad_dir) else $error("quadrature step wrong");
  property p_quad_sel;
    @(posedge mclk) disable iff (!nrst) in_act_reg[14:0] == 15'h0803 |-> mode_quad && !mode_up && !mode_int;
  endproperty
  a_quad_sel: assert property (p_quad_sel) else $error("quadrature code not decoded");
  property p_int;
    @(posedge mclk) disable iff (!nrst) mode_int && in_act_reg[12] && in_act_reg[2] && rise[2] |=> st_reg[2];
  endproperty
  a_int: assert property (p_int) else $error("interrupt 3 not raised");
  property p_adj;
    @(posedge mclk) disable iff (!nrst) adj_reg[0] <= 10'h3e8 && adj_reg[1] <= 10'h3e8;
  endproperty
  a_adj: assert property (p_adj) else $error("adjuster value above full scale");
  property p_pwm_off;
    @(posedge mclk) disable iff (!nrst) mode_pwm && pwm_reg == 7'h00 |=> !out_20;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("zero duty drives output");
  property p_dir;
    @(posedge mclk) disable iff (!nrst) mode_pd && run |=> out_21 == $past(dir);
  endproperty
  a_dir: assert property (p_dir) else $error("direction output wrong");
  property p_one;
    @(posedge mclk) disable iff (!nrst) $onehot0({mode_cw, mode_pd, mode_pwm}) && $onehot0({mode_up, mode_spd, mode_quad, mode_int});
  endproperty
  a_one: assert property (p_one) else $error("two functions active");
  c_scan: cover property (@(posedge mclk) disable iff (!nrst) $rose(scan_reg));
  c_hit: cover property (@(posedge mclk) disable iff (!nrst) ev[0]);
  c_irq: cover property (@(posedge mclk) disable iff (!nrst) $rose(irq));
endmodule : ssio_top

// ---- dv/ssio_field.sv ----
`timescale 1ns/1ps
// Field side: pulse sources, switches and the two adjusters
module ssio_field (
  input wire logic mclk,
  output logic [7:0] din,
  output logic [9:0] adj0_raw,
  output logic [9:0] adj1_raw
);
  // Adjuster 0 sits above full scale so that the clamp is exercised
  initial begin
    din = 8'h00;
    adj0_raw = 10'h3ff;
    adj1_raw = 10'h07b;
  end
  // Pulses of 5 ms, well beyond the short filter used in simulation
  task pulse(input int ch, input int n);
    repeat (n) begin
      din[ch] <= 1'b1;
      repeat (100) @(posedge mclk);
      din[ch] <= 1'b0;
      repeat (100) @(posedge mclk);
    end
  endtask : pulse
  // Steady switch level
  task set_in(input int ch, input logic v);
    din[ch] <= v;
  endtask : set_in
  // One full quadrature cycle on inputs 0 and 1; phase A moves first when up is set
  task quad(input logic up);
    for (int s = 0; s < 4; s++) begin
      din[s[0] ^ !up] <= !s[1];
      repeat (10) @(posedge mclk);
    end
  endtask : quad
endmodule : ssio_field

// ---- dv/special_io_mode_select_test.sv ----
`timescale 1ns/1ps
module special_io_mode_select_test;
  logic mclk, nrst, hsel, hwrite, hreadyout, hresp, out_20, out_21, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] din, din_filt;
  logic [9:0] adj0_raw, adj1_raw;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  ssio_field i_field (.mclk(mclk), .din(din), .adj0_raw(adj0_raw), .adj1_raw(adj1_raw));
  // One ms is shortened to 20 cycles to keep the run short
  ssio_top #(.MS_CYC(20)) i_dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .din(din), .adj0_raw(adj0_raw), .adj1_raw(adj1_raw),
    .din_filt(din_filt), .out_20(out_20), .out_21(out_21), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task finish_test;
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Single AHB transfer; the next call always leaves two idle cycles
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp, nm);
  endtask : rdc
  task rst;
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
  endtask : rst
  task t_regs;
    rdc(ssio_pkg::A_FDLY, 32'h0000000a, "fdly");
    rdc(ssio_pkg::A_SCAN, 32'h00000000, "scan");
    rdc(8'h80, 32'h00000000, "unmapped");
    rdc(ssio_pkg::A_ADJ0, 32'h000003e8, "adj0");
    rdc(ssio_pkg::A_ADJ1, 32'h0000007b, "adj1");
  endtask : t_regs
  // Up-counter with filter on, then rewrites after the first scan
  task t_latch;
    bus(1'b1, ssio_pkg::A_IN_SEL, 32'h00009003);
    bus(1'b1, ssio_pkg::A_OUT_SEL, 32'h00000003);
    bus(1'b1, ssio_pkg::A_FDLY, 32'h00000002);
    bus(1'b1, ssio_pkg::A_SCAN, 32'h00000001);
    bus(1'b1, ssio_pkg::A_IN_SEL, 32'h00000803);
    bus(1'b1, ssio_pkg::A_OUT_SEL, 32'h00000001);
    bus(1'b1, ssio_pkg::A_FDLY, 32'h0000000f);
    rdc(ssio_pkg::A_ACT, 32'h00039003, "active");
    rdc(ssio_pkg::A_SCAN, 32'h00000001, "scan");
  endtask : t_latch
  // A 2 ms filter passes a change after 2 to 3 ms, never before
  task t_filter;
    for (int v = 1; v >= 0; v--) begin
      i_field.set_in(5, v[0]);
      repeat (30) @(posedge mclk);
      chk({31'h0, din_filt[5]}, {31'h0, ~v[0]}, "filt early");
      repeat (40) @(posedge mclk);
      chk({31'h0, din_filt[5]}, {31'h0, v[0]}, "filt late");
    end
  endtask : t_filter
  task t_count;
    bus(1'b1, ssio_pkg::A_SV1, 32'h00000003);
    bus(1'b1, ssio_pkg::A_CTRL, 32'h00000011);
    bus(1'b1, ssio_pkg::A_IMSK, 32'h00000001);
    i_field.pulse(0, 2);
    rdc(ssio_pkg::A_CNT1, 32'h00000002, "count");
    i_field.pulse(2, 1);
    rdc(ssio_pkg::A_CNT1, 32'h00000000, "count reset");
    chk({31'h0, irq}, 32'h00000000, "irq idle");
    i_field.pulse(0, 3);
    rdc(ssio_pkg::A_CNT1, 32'h00000000, "count wrap");
    rdc(ssio_pkg::A_IST, 32'h00000001, "status");
    chk({31'h0, irq}, 32'h00000001, "irq set");
    bus(1'b1, ssio_pkg::A_IST, 32'h00000001);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h00000000, "irq clear");
  endtask : t_count
  // Second reset: interrupt input 1 on the rising edge only
  task t_int;
    rst;
    bus(1'b1, ssio_pkg::A_IN_SEL, 32'h00001005);
    bus(1'b1, ssio_pkg::A_OUT_SEL, 32'h00000007);
    bus(1'b1, ssio_pkg::A_IMSK, 32'h00000004);
    bus(1'b1, ssio_pkg::A_SCAN, 32'h00000001);
    i_field.set_in(2, 1'b1);
    repeat (300) @(posedge mclk);
    rdc(ssio_pkg::A_IST, 32'h00000004, "int rise");
    chk({31'h0, irq}, 32'h00000001, "int irq");
    bus(1'b1, ssio_pkg::A_IST, 32'h00000004);
    i_field.set_in(2, 1'b0);
    repeat (300) @(posedge mclk);
    rdc(ssio_pkg::A_IST, 32'h00000000, "int fall");
    // Pulse/direction at 5000 Hz: first toggle of output 20 lands 100 us after run
    bus(1'b1, ssio_pkg::A_PLS, 32'h00031388);
    repeat (24500) @(posedge mclk);
    chk({31'h0, out_20}, 32'h00000000, "pulse early");
    chk({31'h0, out_21}, 32'h00000001, "direction");
    repeat (1000) @(posedge mclk);
    chk({31'h0, out_20}, 32'h00000001, "pulse late");
  endtask : t_int
  // Third reset: quadrature with the filter at 0 ms, one cycle up then two down
  task t_quad;
    rst;
    bus(1'b1, ssio_pkg::A_IN_SEL, 32'h00008803);
    bus(1'b1, ssio_pkg::A_FDLY, 32'h00000000);
    bus(1'b1, ssio_pkg::A_CTRL, 32'h00000001);
    bus(1'b1, ssio_pkg::A_SCAN, 32'h00000001);
    i_field.quad(1'b1);
    rdc(ssio_pkg::A_CNT1, 32'h00000004, "quad up");
    i_field.quad(1'b0);
    i_field.quad(1'b0);
    rdc(ssio_pkg::A_CNT1, 32'hfffffffc, "quad down");
  endtask : t_quad
  // Hang guard, well above the roughly 30000 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rst;
    t_regs;
    t_latch;
    t_filter;
    t_count;
    t_int;
    t_quad;
    finish_test;
  end
endmodule : special_io_mode_select_test
